// ---- hdl/prs_sequencer.sv ----
// power-up rail sequencer: rail enables, monitor tests, reset release
// Contract
// - core rail enable rises 11 ms after request rising edge, filter included
// - core monitor sampled exactly 10 ms after core enable
// - mid monitor sampled exactly 10 ms after mid enable
// - I/O monitor sampled exactly 10 ms after I/O enable
// - enables rise in order core, mid, I/O, each after prior test
// - reset released 10 ms after I/O monitor test passes
// - reset delay starts only on the I/O test pass
// - any failed test keeps system reset asserted
// - undervoltage excursions shorter than suppression window are ignored
`timescale 1ns/1ns
`include "prs_map.svh"
module prs_sequencer #(
   parameter int EN_DLY_CYC = `PRS_EN_DLY_CYC,
   parameter int MON_CYC = `PRS_MON_CYC,
   parameter int W1_CYC = `PRS_W1_CYC,
   parameter int GLITCH_CYC = `PRS_GLITCH_CYC
) (
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic i_projector_on_request,
   input wire logic i_core_rail_good,
   input wire logic i_mid_rail_good,
   input wire logic i_io_rail_good,
   output logic o_core_rail_enable,
   output logic o_mid_rail_enable,
   output logic o_io_rail_enable,
   output logic o_system_reset_n,
   output logic o_sequence_failed
);
   // ***********************************************************
   // input synchronisers
   // ***********************************************************
   logic [3:0] sync1;
   logic [3:0] sync2;
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         sync1 <= 4'h0;
         sync2 <= 4'h0;
      end else begin
         sync1 <= {i_io_rail_good, i_mid_rail_good, i_core_rail_good,
                   i_projector_on_request};
         sync2 <= sync1;
      end
   end

   // ***********************************************************
   // undervoltage glitch suppression
   // ***********************************************************
   // a monitor level changes only after holding 20 us; shorter
   // dips are ignored
   prs_pkg::prs_rails_t good;
   genvar g;
   generate
      for (g = 0; g < `PRS_RAILS; g++) begin : g_filt
         logic [31:0] cnt;
         always_ff @(posedge i_clk_sys) begin
            if (i_reset) begin
               cnt <= 32'h0;
               good[g] <= 1'b0;
            end else if (sync2[g + 1] == good[g]) begin
               cnt <= 32'h0;
            end else if (cnt >= 32'(GLITCH_CYC - 1)) begin
               cnt <= 32'h0;
               good[g] <= sync2[g + 1];
            end else begin
               cnt <= cnt + 32'h1;
            end
         end
      end
   endgenerate

   // ***********************************************************
   // sequencer
   // ***********************************************************
   wire logic req = sync2[0];
   prs_pkg::prs_state_t state;
   logic [31:0] timer;
   logic [1:0] rail;
   prs_pkg::prs_rails_t en;
   logic rail_ok;
   always_comb begin
      unique case (rail)
         2'h0: rail_ok = good.core;
         2'h1: rail_ok = good.mid;
         default: rail_ok = good.io;
      endcase
   end

   // request filter (2 sync cycles) is inside the 11 ms budget
   always_ff @(posedge i_clk_sys) begin
      if (i_reset || !req) begin
         state <= prs_pkg::PRS_IDLE;
         timer <= 32'h0;
         rail <= 2'h0;
         en <= 3'h0;
      end else begin
         unique case (state)
            prs_pkg::PRS_IDLE: begin
               state <= prs_pkg::PRS_WAIT_EN;
               timer <= 32'h3;
            end
            prs_pkg::PRS_WAIT_EN: begin
               if (timer >= 32'(EN_DLY_CYC - 1)) begin
                  state <= prs_pkg::PRS_RAIL_MON;
                  en.core <= 1'b1;
                  timer <= 32'h0;
               end else begin
                  timer <= timer + 32'h1;
               end
            end
            prs_pkg::PRS_RAIL_MON: begin
               if (timer < 32'(MON_CYC - 1)) begin
                  timer <= timer + 32'h1;
               end else if (!rail_ok) begin
                  state <= prs_pkg::PRS_FAIL;
               end else if (rail == 2'h2) begin
                  state <= prs_pkg::PRS_RST_DLY;
                  timer <= 32'h0;
               end else begin
                  rail <= rail + 2'h1;
                  timer <= 32'h0;
                  if (rail == 2'h0) begin
                     en.mid <= 1'b1;
                  end else begin
                     en.io <= 1'b1;
                  end
               end
            end
            prs_pkg::PRS_RST_DLY: begin
               if (timer >= 32'(W1_CYC - 1)) begin
                  state <= prs_pkg::PRS_RUN;
               end else begin
                  timer <= timer + 32'h1;
               end
            end
            prs_pkg::PRS_RUN: state <= prs_pkg::PRS_RUN;
            prs_pkg::PRS_FAIL: state <= prs_pkg::PRS_FAIL;
            default: state <= prs_pkg::PRS_IDLE;
         endcase
      end
   end

   // ***********************************************************
   // outputs, all registered
   // ***********************************************************
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         o_core_rail_enable <= 1'b0;
         o_mid_rail_enable <= 1'b0;
         o_io_rail_enable <= 1'b0;
         o_system_reset_n <= 1'b0;
         o_sequence_failed <= 1'b0;
      end else begin
         o_core_rail_enable <= en.core;
         o_mid_rail_enable <= en.mid;
         o_io_rail_enable <= en.io;
         o_system_reset_n <= (state == prs_pkg::PRS_RUN);
         o_sequence_failed <= (state == prs_pkg::PRS_FAIL);
      end
   end

   // ***********************************************************
   // assertions
   // ***********************************************************
   property p_idle_low;
      @(posedge i_clk_sys) disable iff (i_reset)
      !req |=> ##1 (!o_core_rail_enable && !o_system_reset_n);
   endproperty
   a_idle_low: assert property (p_idle_low)
      else $error("outputs active while request low");
   property p_order_mid;
      @(posedge i_clk_sys) disable iff (i_reset)
      $rose(o_mid_rail_enable) |-> o_core_rail_enable;
   endproperty
   a_order_mid: assert property (p_order_mid)
      else $error("mid enable before core");
   property p_order_io;
      @(posedge i_clk_sys) disable iff (i_reset)
      $rose(o_io_rail_enable) |-> o_mid_rail_enable;
   endproperty
   a_order_io: assert property (p_order_io)
      else $error("io enable before mid");
   property p_fail_hold;
      @(posedge i_clk_sys) disable iff (i_reset)
      o_sequence_failed |-> !o_system_reset_n;
   endproperty
   a_fail_hold: assert property (p_fail_hold)
      else $error("reset released after failure");
   property p_rst_after_io;
      @(posedge i_clk_sys) disable iff (i_reset)
      $rose(o_system_reset_n) |-> o_io_rail_enable && good.io;
   endproperty
   a_rst_after_io: assert property (p_rst_after_io)
      else $error("reset released without io rail");
   property p_mon_wait;
      @(posedge i_clk_sys) disable iff (i_reset)
      (state == prs_pkg::PRS_RAIL_MON && timer < 32'(MON_CYC - 1))
         |=> state != prs_pkg::PRS_FAIL;
   endproperty
   a_mon_wait: assert property (p_mon_wait)
      else $error("monitor sampled early");
   property p_test_pass;
      @(posedge i_clk_sys) disable iff (i_reset)
      (req && state == prs_pkg::PRS_RAIL_MON && rail == 2'h2 &&
       timer == 32'(MON_CYC - 1) && good.io) |=> state == prs_pkg::PRS_RST_DLY;
   endproperty
   a_test_pass: assert property (p_test_pass)
      else $error("io pass did not start reset delay");
   // a change must follow a full window of disagreement
   property p_filter;
      @(posedge i_clk_sys) disable iff (i_reset)
      (!$past(i_reset) && $changed(good.core)) |->
         ($past(sync2[1]) == good.core &&
          $past(g_filt[0].cnt) == 32'(GLITCH_CYC - 1));
   endproperty
   a_filter: assert property (p_filter)
      else $error("filter changed against input");
   c_run: cover property (@(posedge i_clk_sys) $rose(o_system_reset_n));
   c_fail: cover property (@(posedge i_clk_sys) $rose(o_sequence_failed));
   c_io: cover property (@(posedge i_clk_sys) $rose(o_io_rail_enable));
endmodule : prs_sequencer

// ---- hdl/prs_map.svh ----
// timing constants for the power-up rail sequencer
`ifndef PRS_MAP_SVH
`define PRS_MAP_SVH
`define PRS_CLK_MHZ 100
`define PRS_T_EN_DLY_MS 11
`define PRS_T_MON_MS 10
`define PRS_T_W1_MS 10
`define PRS_T_GLITCH_US 20
`define PRS_CYC_PER_MS (`PRS_CLK_MHZ * 1000)
`define PRS_EN_DLY_CYC (`PRS_T_EN_DLY_MS * `PRS_CYC_PER_MS)
`define PRS_MON_CYC (`PRS_T_MON_MS * `PRS_CYC_PER_MS)
`define PRS_W1_CYC (`PRS_T_W1_MS * `PRS_CYC_PER_MS)
`define PRS_GLITCH_CYC (`PRS_T_GLITCH_US * `PRS_CLK_MHZ)
`define PRS_RAILS 3
`endif

// ---- hdl/prs_pkg.sv ----
// types of the power-up rail sequencer
package prs_pkg;
   typedef enum logic [2:0] {
      PRS_IDLE = 3'h0,
      PRS_WAIT_EN = 3'h1,
      PRS_RAIL_MON = 3'h2,
      PRS_RST_DLY = 3'h3,
      PRS_RUN = 3'h4,
      PRS_FAIL = 3'h5
   } prs_state_t;
   typedef struct packed {
      logic io;
      logic mid;
      logic core;
   } prs_rails_t;
endpackage : prs_pkg

// ---- sim/prs_rail_model.sv ----
// regulator model: rail good follows its enable after a short ramp
`timescale 1ns/1ns
module prs_rail_model #(
   parameter int RAMP_CYC = 3
) (
   input wire logic i_clk_sys,
   input wire logic i_enable,
   input wire logic i_fault,
   input wire logic i_dip,
   output logic o_good
);
   int ramp = 0;
   always_ff @(posedge i_clk_sys) begin
      ramp <= !i_enable ? 0 : (ramp < RAMP_CYC) ? ramp + 1 : ramp;
   end
   // valid well before the sample point unless a fault or a dip is commanded
   assign o_good = (ramp == RAMP_CYC) && !i_fault && !i_dip;
endmodule : prs_rail_model

// ---- sim/tb.sv ----
// self-checking bench of the power-up rail sequencer
`timescale 1ns/1ns
module tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic req = 1'b0;
   logic rst_n;
   logic failed;
   prs_pkg::prs_rails_t en, good;
   prs_pkg::prs_rails_t fault = '0;
   prs_pkg::prs_rails_t dip = '0;
   // board variant: core enable drives every supply
   logic one_enable = 1'b0;
   int err_total = 0;
   int samples_checked = 0;
   always #5 clk = ~clk;
   // small counts keep the run short: 40, 20, 20, 4
   prs_sequencer #(.EN_DLY_CYC(40), .MON_CYC(20), .W1_CYC(20),
      .GLITCH_CYC(4)) dut_u (.i_clk_sys(clk), .i_reset(rst),
      .i_projector_on_request(req), .i_core_rail_good(good.core),
      .i_mid_rail_good(good.mid), .i_io_rail_good(good.io),
      .o_core_rail_enable(en.core), .o_mid_rail_enable(en.mid),
      .o_io_rail_enable(en.io), .o_system_reset_n(rst_n),
      .o_sequence_failed(failed));
   prs_rail_model rc_u (.i_clk_sys(clk), .i_enable(en.core),
      .i_fault(fault.core), .i_dip(dip.core), .o_good(good.core));
   prs_rail_model rm_u (.i_clk_sys(clk),
      .i_enable(one_enable ? en.core : en.mid),
      .i_fault(fault.mid), .i_dip(dip.mid), .o_good(good.mid));
   prs_rail_model ri_u (.i_clk_sys(clk),
      .i_enable(one_enable ? en.core : en.io),
      .i_fault(fault.io), .i_dip(dip.io), .o_good(good.io));
   function automatic logic [3:0] outs();
      return {rst_n, en.io, en.mid, en.core};
   endfunction : outs
   task automatic finish_test();
      $display("errors %0d checks %0d", err_total, samples_checked);
      if (err_total == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : finish_test
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   // bounded wait for one output bit; n counts cycles waited
   task automatic wait_for(input int sel, output int n);
      logic [3:0] cur;
      n = 0;
      cur = outs();
      while (cur[sel] !== 1'b1) begin
         tick(1);
         n++;
         cur = outs();
         if (n > 200) begin
            err_total++;
            finish_test();
         end
      end
   endtask : wait_for
   task automatic power_off();
      req = 1'b0;
      tick(4);
      check(outs(), 4'h0);
      check(failed, 1'b0);
      fault = '0;
      tick(2);
   endtask : power_off
   // full sequence; a short dip on the mid rail must be ignored
   task automatic power_up_ok(input bit glitch);
      int n;
      int off;
      req = 1'b1;
      wait_for(0, n);
      check(n >= 38 && n <= 42, 1'b1);
      wait_for(1, n);
      check(n, 20);
      off = 0;
      if (glitch) begin
         tick(8);
         dip.mid = 1'b1;
         tick(2);
         dip.mid = 1'b0;
         off = 10;
      end
      wait_for(2, n);
      check(n + off, 20);
      wait_for(3, n);
      check(n, 40);
      tick(30);
      check(outs(), 4'hF);
      check(failed, 1'b0);
      power_off();
   endtask : power_up_ok
   // a rail missing at its sample point stops the sequence
   task automatic rail_fail(input int i);
      fault = 3'h1 << i;
      req = 1'b1;
      tick(150);
      check(outs(), (4'h1 << (i + 1)) - 4'h1);
      check(failed, 1'b1);
      power_off();
   endtask : rail_fail
   initial begin
      tick(8);
      rst = 1'b0;
      tick(1);
      check(outs(), 4'h0);
      power_up_ok(1'b0);
      for (int i = 0; i < 3; i++) begin
         rail_fail(i);
         power_up_ok(1'b0);
      end
      power_up_ok(1'b1);
      one_enable = 1'b1;
      power_up_ok(1'b0);
      one_enable = 1'b0;
      finish_test();
   end
endmodule : tb
